// ---- cio_ports.sv ----
// Top of the configurable port block with its APB register file.
module cio_ports
   import cio_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [P0_W-1:0]  p0_i,
   output logic      [P0_W-1:0]  p0_o,
   output logic      [P0_W-1:0]  p0_oe,
   output logic      [P0_W-1:0]  p0_weak_oe,
   input  wire logic [P1_W-1:0]  p1_i,
   output logic      [P1_W-1:0]  p1_o,
   output logic      [P1_W-1:0]  p1_oe,
   output logic      [P1_W-1:0]  p1_weak_oe,
   input  wire logic [P3_W-1:0]  p3_i,
   output logic      [P3_W-1:0]  p3_o,
   output logic      [P3_W-1:0]  p3_oe,
   output logic      [P3_W-1:0]  p3_weak_oe,
   output logic                  ext_reset_req,
   output logic      [4:0]       usable_pins
);

   // Register state.
   logic [7:0] p0_latch_r;
   logic [7:0] p1_latch_r;
   logic [1:0] p3_latch_r;
   logic [7:0] p0_cfga_r;
   logic [7:0] p0_cfgb_r;
   logic [7:0] p1_cfga_r;
   logic [7:0] p1_cfgb_r;
   logic [1:0] p3_cfga_r;
   logic [1:0] p3_cfgb_r;
   logic [7:0] port0_digital_input_disable_r;
   logic       reset_pin_function_enable_r;
   logic [1:0] clk_src_r;
   logic [7:0] p0_in_r;
   logic [7:0] p1_in_r;
   logic [1:0] p3_in_r;
   logic [31:0] prdata_r;
   logic       pslverr_r;
   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;

   // Address decode helper used for both write and error paths.
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a <= ADDR_STATUS) && (a[1:0] == 2'h0);
   endfunction

   // Zero-extend a byte into a bus word.
   function automatic logic [31:0] to_word(input logic [7:0] b);
      to_word = {24'h0, b};
   endfunction

   // Zero-wait-state slave: access completes in its first access cycle.
   assign pready  = 1'b1;
   assign addr_ok = addr_mapped(paddr);
   assign wr_en   = psel && penable && pwrite && addr_ok;
   assign rd_en   = psel && !penable && !pwrite;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r && psel && penable;

   // Output latches; written as one byte per port, two bits for port 3.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         p0_latch_r <= LATCH_RST;
         p1_latch_r <= LATCH_RST;
         p3_latch_r <= LATCH_RST[1:0];
      end else if (wr_en) begin
         case (paddr)
            ADDR_P0_DATA: p0_latch_r <= pwdata[7:0];
            ADDR_P1_DATA: p1_latch_r <= pwdata[7:0];
            ADDR_P3_DATA: p3_latch_r <= pwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // Drive type configuration; reset leaves every pin input-only.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         p0_cfga_r <= CFGA_RST;
         p0_cfgb_r <= CFGB_RST;
         p1_cfga_r <= CFGA_RST;
         p1_cfgb_r <= CFGB_RST;
         p3_cfga_r <= CFGA_RST[1:0];
         p3_cfgb_r <= CFGB_RST[1:0];
      end else if (wr_en) begin
         case (paddr)
            ADDR_P0_CFGA: p0_cfga_r <= pwdata[7:0];
            ADDR_P0_CFGB: p0_cfgb_r <= pwdata[7:0];
            ADDR_P1_CFGA: p1_cfga_r <= pwdata[7:0];
            ADDR_P1_CFGB: p1_cfgb_r <= pwdata[7:0];
            ADDR_P3_CFGA: p3_cfga_r <= pwdata[1:0];
            ADDR_P3_CFGB: p3_cfgb_r <= pwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // Digital input disable; only bits one to five exist.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port0_digital_input_disable_r <= DIDIS_RST;
      end else if (wr_en && paddr == ADDR_P0_DIDIS) begin
         port0_digital_input_disable_r <= pwdata[7:0] & DIDIS_MASK;
      end
   end

   // Options: reset pin function and clock source selection.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reset_pin_function_enable_r <= 1'b0;
         clk_src_r                   <= CLKSRC_INTERNAL;
      end else if (wr_en && paddr == ADDR_OPTIONS) begin
         reset_pin_function_enable_r <= pwdata[OPT_RPE_BIT];
         clk_src_r <= pwdata[OPT_CLK_LSB +: 2];
      end
   end

   // Pin inputs are registered so reads see a stable sample.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         p0_in_r <= 8'h00;
         p1_in_r <= 8'h00;
         p3_in_r <= 2'h0;
      end else begin
         p0_in_r <= p0_i & ~port0_digital_input_disable_r;
         p1_in_r <= p1_i;
         p3_in_r <= p3_i;
      end
   end

   // External reset request, high while the sampled reset pin is low and the pin is in reset role.
   always_comb begin
      ext_reset_req = reset_pin_function_enable_r &&
                      !p1_in_r[RST_PIN_BIT];
   end

   // Pins lost to the crystal (two), external clock (one) and reset (one).
   always_comb begin
      usable_pins = PINS_MAX;
      case (clk_src_r)
         CLKSRC_EXTERNAL: usable_pins = PINS_MAX - 5'd1;
         CLKSRC_CRYSTAL:  usable_pins = PINS_MAX - 5'd2;
         default:         usable_pins = PINS_MAX;
      endcase
      if (reset_pin_function_enable_r) begin
         usable_pins = usable_pins - 5'd1;
      end
   end

   // Read data is captured in the setup cycle and held for the access.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_r  <= 32'h0;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_r <= !addr_ok;
         prdata_r  <= 32'h0;
         if (rd_en) begin
            case (paddr)
               ADDR_P0_DATA:  prdata_r <= to_word(p0_in_r);
               ADDR_P1_DATA:  prdata_r <= to_word(p1_in_r);
               ADDR_P3_DATA:  prdata_r <= to_word({6'h0, p3_in_r});
               ADDR_P0_CFGA:  prdata_r <= to_word(p0_cfga_r);
               ADDR_P0_CFGB:  prdata_r <= to_word(p0_cfgb_r);
               ADDR_P1_CFGA:  prdata_r <= to_word(p1_cfga_r);
               ADDR_P1_CFGB:  prdata_r <= to_word(p1_cfgb_r);
               ADDR_P3_CFGA:  prdata_r <= to_word({6'h0, p3_cfga_r});
               ADDR_P3_CFGB:  prdata_r <= to_word({6'h0, p3_cfgb_r});
               ADDR_P0_DIDIS:
                  prdata_r <= to_word(port0_digital_input_disable_r);
               ADDR_OPTIONS:
                  prdata_r <= to_word({5'h0, clk_src_r,
                                       reset_pin_function_enable_r});
               ADDR_STATUS:
                  prdata_r <= to_word({3'h0, usable_pins});
               default: prdata_r <= 32'h0;
            endcase
         end
      end
   end

   // Pin drivers for port 0; no restricted pins here.
   for (genvar i = 0; i < P0_W; i++) begin : g_p0
      cio_pin_drv u_drv (
         .cfga        (p0_cfga_r[i]),
         .cfgb        (p0_cfgb_r[i]),
         .latch       (p0_latch_r[i]),
         .force_input (1'b0),
         .od_only     (1'b0),
         .pin_o       (p0_o[i]),
         .pin_oe      (p0_oe[i]),
         .pin_weak_oe (p0_weak_oe[i])
      );
   end

   // Port 1 holds the reset pin and the two serial pins.
   for (genvar i = 0; i < P1_W; i++) begin : g_p1
      cio_pin_drv u_drv (
         .cfga        (p1_cfga_r[i]),
         .cfgb        (p1_cfgb_r[i]),
         .latch       (p1_latch_r[i]),
         .force_input (i == RST_PIN_BIT),
         .od_only     (i == SCL_PIN_BIT || i == SDA_PIN_BIT),
         .pin_o       (p1_o[i]),
         .pin_oe      (p1_oe[i]),
         .pin_weak_oe (p1_weak_oe[i])
      );
   end

   // Port 3 is only two pins wide.
   for (genvar i = 0; i < P3_W; i++) begin : g_p3
      cio_pin_drv u_drv (
         .cfga        (p3_cfga_r[i]),
         .cfgb        (p3_cfgb_r[i]),
         .latch       (p3_latch_r[i]),
         .force_input (1'b0),
         .od_only     (1'b0),
         .pin_o       (p3_o[i]),
         .pin_oe      (p3_oe[i]),
         .pin_weak_oe (p3_weak_oe[i])
      );
   end

endmodule

// ---- cio_pkg.sv ----
// Package with register map, field layout and drive type codes for the port block.
package cio_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] ADDR_P0_DATA  = 8'h00;
   localparam logic [7:0] ADDR_P1_DATA  = 8'h04;
   localparam logic [7:0] ADDR_P3_DATA  = 8'h08;
   localparam logic [7:0] ADDR_P0_CFGA  = 8'h0c;
   localparam logic [7:0] ADDR_P0_CFGB  = 8'h10;
   localparam logic [7:0] ADDR_P1_CFGA  = 8'h14;
   localparam logic [7:0] ADDR_P1_CFGB  = 8'h18;
   localparam logic [7:0] ADDR_P3_CFGA  = 8'h1c;
   localparam logic [7:0] ADDR_P3_CFGB  = 8'h20;
   localparam logic [7:0] ADDR_P0_DIDIS = 8'h24;
   localparam logic [7:0] ADDR_OPTIONS  = 8'h28;
   localparam logic [7:0] ADDR_STATUS   = 8'h2c;

   // Port widths.
   localparam int P0_W = 8;
   localparam int P1_W = 8;
   localparam int P3_W = 2;

   // Drive type selector codes {cfgb, cfga}.
   typedef enum logic [1:0] {
      CIO_QUASI     = 2'h0,
      CIO_PUSH_PULL = 2'h1,
      CIO_INPUT     = 2'h2,
      CIO_OPEN      = 2'h3
   } cio_drive_t;

   // Reset values: all pins input-only, so cfgb set, cfga clear.
   localparam logic [7:0] CFGA_RST  = 8'h00;
   localparam logic [7:0] CFGB_RST  = 8'hff;
   localparam logic [7:0] LATCH_RST = 8'hff;
   localparam logic [7:0] DIDIS_RST = 8'h00;

   // Field positions.
   localparam logic [7:0] DIDIS_MASK   = 8'h3e;
   localparam int         RST_PIN_BIT  = 5;
   localparam int         SCL_PIN_BIT  = 2;
   localparam int         SDA_PIN_BIT  = 3;
   localparam int         OPT_RPE_BIT  = 0;
   localparam int         OPT_CLK_LSB  = 1;

   // Clock source codes held in the options register.
   localparam logic [1:0] CLKSRC_INTERNAL = 2'h0;
   localparam logic [1:0] CLKSRC_EXTERNAL = 2'h1;
   localparam logic [1:0] CLKSRC_CRYSTAL  = 2'h2;

   // Usable pin counts.
   localparam logic [4:0] PINS_MAX = 5'd18;

endpackage

// ---- cio_pin_drv.sv ----
// One pin's driver: decodes the drive type into strong and weak enables.
module cio_pin_drv
   import cio_pkg::*;
(
   input  wire logic       cfga,
   input  wire logic       cfgb,
   input  wire logic       latch,
   input  wire logic       force_input,
   input  wire logic       od_only,
   output logic            pin_o,
   output logic            pin_oe,
   output logic            pin_weak_oe
);

   cio_drive_t sel;

   // Restricted pins fold disallowed codes onto input-only; serial pins keep open-drain.
   always_comb begin
      sel = cio_drive_t'({cfgb, cfga});
      if (force_input) begin
         sel = CIO_INPUT;
      end else if (od_only && sel != CIO_OPEN) begin
         sel = CIO_INPUT;
      end
   end

   // Low is strong in every mode but input-only; high is strong only in push-pull mode.
   always_comb begin
      pin_o       = latch;
      pin_oe      = 1'b0;
      pin_weak_oe = 1'b0;
      case (sel)
         CIO_QUASI: begin
            pin_oe      = ~latch;
            pin_weak_oe = latch;
         end
         CIO_PUSH_PULL: begin
            pin_oe = 1'b1;
         end
         CIO_OPEN: begin
            pin_oe = ~latch;
         end
         CIO_INPUT: begin
            pin_oe = 1'b0;
         end
         default: begin
            pin_oe = 1'b0;
         end
      endcase
   end

endmodule

// ---- cio_ports_asserts.sv ----
// Checker for the port block's pin drive and bus answers.
module cio_ports_asserts (
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic [cio_pkg::P0_W-1:0]  p0_o,
   input wire logic [cio_pkg::P0_W-1:0]  p0_oe,
   input wire logic [cio_pkg::P0_W-1:0]  p0_weak_oe,
   input wire logic [cio_pkg::P1_W-1:0]  p1_i,
   input wire logic [cio_pkg::P1_W-1:0]  p1_o,
   input wire logic [cio_pkg::P1_W-1:0]  p1_oe,
   input wire logic [cio_pkg::P1_W-1:0]  p1_weak_oe,
   input wire logic                      ext_reset_req,
   input wire logic [4:0]                usable_pins
);
   import cio_pkg::*;
   logic rst_pin;
   // The reset pin level alone, so its history can be taken.
   assign rst_pin = p1_i[RST_PIN_BIT];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Steps of a port 0 latch write and of a refused access.
   sequence s_p0_wr;
      psel && penable && pwrite && paddr == ADDR_P0_DATA;
   endsequence
   sequence s_bad;
      psel && penable && (paddr > ADDR_STATUS || paddr[1:0] != 2'h0);
   endsequence
   AST_RESET_INPUT: assert property (
      $rose(rst_n) |-> (p0_oe | p1_oe | p0_weak_oe | p1_weak_oe) == 8'h00
      && usable_pins == PINS_MAX) else $error("Drivers on after reset.");
   AST_RST_PIN_IN: assert property (
      !p1_oe[RST_PIN_BIT] && !p1_weak_oe[RST_PIN_BIT])
      else $error("Reset pin driven.");
   AST_SERIAL_OD: assert property (
      p1_weak_oe[3:2] == 2'h0 && (p1_oe[3:2] & p1_o[3:2]) == 2'h0)
      else $error("Serial pin driven high.");
   AST_WEAK_HIGH: assert property (
      (p0_weak_oe & (p0_oe | ~p0_o)) == 8'h00)
      else $error("Weak pull-up with low latch or strong drive.");
   AST_LATCH_OUT: assert property (
      s_p0_wr |=> p0_o == 8'($past(pwdata)))
      else $error("Port 0 latch not updated.");
   AST_ZERO_WAIT: assert property (
      psel && penable |-> pready) else $error("Access not answered.");
   AST_REFUSED: assert property (
      s_bad |-> pslverr && prdata == 32'h0)
      else $error("Unmapped access not refused.");
   AST_RESET_REQ: assert property (
      ext_reset_req |-> !$past(rst_pin))
      else $error("Reset request without low pin.");
   AST_PIN_COUNT: assert property (
      usable_pins <= PINS_MAX && usable_pins >= 5'd15)
      else $error("Pin count out of range.");
endmodule

bind cio_ports cio_ports_asserts chk (.clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .p0_o, .p0_oe,
   .p0_weak_oe, .p1_i, .p1_o, .p1_oe, .p1_weak_oe, .ext_reset_req,
   .usable_pins);

// ---- cio_ext_dev.sv ----
// Model of the outside parts on one port: board pull-ups and sinks.
module cio_ext_dev #(
   parameter int W = 8
) (
   input  wire logic [W-1:0]  o,
   input  wire logic [W-1:0]  oe,
   input  wire logic [W-1:0]  pull_lo,
   output logic      [W-1:0]  pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // A strong driver wins; a released line is lifted by the board
   // pull-up unless a part sinks it, so open-drain highs are real.
   assign pin = (oe & o) | (~oe & ~pull_lo);
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the port block over APB.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cio_pkg::*;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        ext_reset_req;
   logic [7:0]  paddr, p0_i, p0_o, p0_oe, p0_wk, p0_lo;
   logic [7:0]  p1_i, p1_o, p1_oe, p1_wk, p1_lo;
   logic [1:0]  p3_i, p3_o, p3_oe, p3_wk, p3_lo;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] e;
   logic [4:0]  usable_pins;
   int          bad_count = 0;
   int          checks = 0;
   int          cyc = 0;
   cio_ports dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .p0_i, .p0_o, .p0_oe, .p0_weak_oe(p0_wk),
      .p1_i, .p1_o, .p1_oe, .p1_weak_oe(p1_wk), .p3_i, .p3_o, .p3_oe,
      .p3_weak_oe(p3_wk), .ext_reset_req, .usable_pins);
   cio_ext_dev #(.W(8)) ext0 (.o(p0_o), .oe(p0_oe), .pull_lo(p0_lo),
      .pin(p0_i));
   cio_ext_dev #(.W(8)) ext1 (.o(p1_o), .oe(p1_oe), .pull_lo(p1_lo),
      .pin(p1_i));
   cio_ext_dev #(.W(2)) ext3 (.o(p3_o), .oe(p3_oe), .pull_lo(p3_lo),
      .pin(p3_i));
   // Free-running clock at 100 ns.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // A hung handshake ends the run as a failure.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One transfer, held until pready is seen high, then an idle cycle.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, x);
   endtask
   task automatic reset_pulse();
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   // Strong and weak enables expected for a code and latch value.
   function automatic logic [15:0] drv(input logic [1:0] c,
                                       input logic [7:0] l);
      case (c)
         CIO_QUASI: return {~l, l};
         CIO_PUSH_PULL: return {8'hff, 8'h00};
         CIO_OPEN: return {~l, 8'h00};
         default: return 16'h0;
      endcase
   endfunction
   // Main sequence; pins idle released so pull-ups set their level.
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {p0_lo, p1_lo, p3_lo} = '0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("oe", {p0_oe, p1_oe, p3_oe}, 32'h0);
      chk("wk", {p0_wk, p1_wk, p3_wk}, 32'h0);
      rdc("cfgb", ADDR_P0_CFGB, 32'hff);
      rdc("count", ADDR_STATUS, 32'd18);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_P0_DATA, 32'h5a);
         apb(1'b1, ADDR_P0_CFGA, {32{c[0]}});
         apb(1'b1, ADDR_P0_CFGB, {32{c[1]}});
         e = drv(c[1:0], 8'h5a);
         chk("p0 drive", {p0_oe, p0_wk}, e);
         chk("p0 out", p0_o, 8'h5a);
         rdc("p0 pins", ADDR_P0_DATA, {24'h0, 8'h5a | ~e[15:8]});
      end
      apb(1'b1, ADDR_P0_DATA, 32'hff);
      apb(1'b1, ADDR_P0_CFGA, 32'h0);
      apb(1'b1, ADDR_P0_CFGB, 32'h0);
      p0_lo <= 8'h0f;
      // Let the input flop take the new pin levels before the read.
      repeat (2) @(posedge clk);
      rdc("quasi in", ADDR_P0_DATA, 32'hf0);
      chk("ok err", err, 1'b0);
      // Analog pins go input-only before their digital input is cut.
      apb(1'b1, ADDR_P0_CFGB, 32'hff);
      apb(1'b1, ADDR_P0_DIDIS, 32'hff);
      rdc("didis", ADDR_P0_DIDIS, 32'h3e);
      rdc("masked", ADDR_P0_DATA, 32'hc0);
      reset_pulse();
      rdc("didis", ADDR_P0_DIDIS, 32'h0);
      chk("p0 oe", {p0_oe, p0_wk}, 32'h0);
      apb(1'b1, ADDR_P1_DATA, 32'h0);
      apb(1'b1, ADDR_P1_CFGA, 32'hff);
      chk("p1 od", {p1_oe, p1_wk}, 32'hdf00);
      apb(1'b1, ADDR_P1_CFGB, 32'h0);
      chk("p1 pp", {p1_oe, p1_wk}, 32'hd300);
      apb(1'b1, ADDR_P1_DATA, 32'hff);
      apb(1'b1, ADDR_P1_CFGA, 32'h0);
      chk("p1 qb", {p1_oe, p1_wk}, 32'h00d3);
      apb(1'b1, ADDR_P3_CFGA, 32'hffffffff);
      apb(1'b1, ADDR_P3_CFGB, 32'h0);
      apb(1'b1, ADDR_P3_DATA, 32'h2);
      chk("p3", {p3_oe, p3_o}, 32'he);
      rdc("p3 cfga", ADDR_P3_CFGA, 32'h3);
      for (int c = 0; c < 3; c++) begin
         for (int r = 0; r < 2; r++) begin
            apb(1'b1, ADDR_OPTIONS, 32'(c * 2 + r));
            rdc("count", ADDR_STATUS, 32'(18 - c - r));
         end
      end
      p1_lo <= 8'h20;
      repeat (3) @(posedge clk);
      chk("ext rst", ext_reset_req, 1'b1);
      apb(1'b1, ADDR_OPTIONS, 32'h0);
      chk("ext rst", ext_reset_req, 1'b0);
      apb(1'b1, 8'h30, 32'hff);
      chk("err", err, 1'b1);
      apb(1'b0, 8'h0d, 32'h0);
      chk("err", err, 1'b1);
      chk("bad rd", rd, 32'h0);
      test_done();
   end
endmodule
